// *** src/per_channel_limit_trim_slot_regs.v ***
// APB register bank for per-input limits, hysteresis, trims and sequencer slots
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "limit_trim_regs.vh"

module per_channel_limit_trim_slot_regs (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  output wire [95:0] max_limit_reg,
  output wire [95:0] min_limit_reg,
  output wire [95:0] limit_band_reg,
  output wire [127:0] zero_trim_reg,
  output wire [127:0] scale_trim_reg,
  input wire [6:0] slot_index,
  output reg [3:0] slot_input_select,
  output reg slot_select_valid
);

  // ----------------------------------------------------------------
  // Register groups
  // ----------------------------------------------------------------
  localparam [2:0] G_NONE = 3'd0;
  localparam [2:0] G_UPPER = 3'd1;
  localparam [2:0] G_LOWER = 3'd2;
  localparam [2:0] G_HYST = 3'd3;
  localparam [2:0] G_OFFSET = 3'd4;
  localparam [2:0] G_GAIN = 3'd5;
  localparam [2:0] G_SLOT = 3'd6;
  localparam [2:0] G_STATUS = 3'd7;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Map a byte address to its register group; odd per-channel indexes miss
  function [2:0] group_of;
    input [11:0] addr;
    reg [8:0] idx;
    begin
      idx = addr[`LT_IDX_MSB:`LT_IDX_LSB];
      if (addr[1:0] != 2'b00 || addr[`LT_ADDR_TOP]) begin
        group_of = G_NONE;
      end else if ((idx & `LT_CHAN_MASK) == `LT_UPPER_IDX) begin
        group_of = G_UPPER;
      end else if ((idx & `LT_CHAN_MASK) == `LT_LOWER_IDX) begin
        group_of = G_LOWER;
      end else if ((idx & `LT_CHAN_MASK) == `LT_HYST_IDX) begin
        group_of = G_HYST;
      end else if ((idx & `LT_CHAN_MASK) == `LT_OFFSET_IDX) begin
        group_of = G_OFFSET;
      end else if ((idx & `LT_CHAN_MASK) == `LT_GAIN_IDX) begin
        group_of = G_GAIN;
      end else if ((idx & `LT_SLOT_MASK) == `LT_SLOT_IDX) begin
        group_of = G_SLOT;
      end else if (idx == `LT_STATUS_IDX) begin
        group_of = G_STATUS;
      end else begin
        group_of = G_NONE;
      end
    end
  endfunction

  // Pick one channel's twelve-bit field out of a flat bank
  function [11:0] pick12;
    input [95:0] flat;
    input [2:0] chan;
    begin
      pick12 = flat[chan*12 +: 12];
    end
  endfunction

  // Pick one channel's sixteen-bit word out of a flat bank
  function [15:0] pick16;
    input [127:0] flat;
    input [2:0] chan;
    begin
      pick16 = flat[chan*16 +: 16];
    end
  endfunction

  // Byte-lane merge of new write data over the current value
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] wdata;
    input [1:0] strb;
    begin
      merge16[7:0] = strb[0] ? wdata[7:0] : old[7:0];
      merge16[15:8] = strb[1] ? wdata[15:8] : old[15:8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [8:0] idx;
  wire [2:0] grp;
  wire [2:0] chan;
  wire [6:0] bus_slot;
  wire access;
  wire commit;
  wire wr_commit;

  assign idx = paddr[`LT_IDX_MSB:`LT_IDX_LSB];
  assign grp = group_of(paddr);
  // Per-channel registers sit on every second index
  assign chan = idx[3:1];
  assign bus_slot = idx[6:0];
  // Access phase, and the edge where the transfer completes
  assign access = psel & penable;
  assign commit = access & pready;
  assign wr_commit = commit & pwrite;

  // ----------------------------------------------------------------
  // Current value of the addressed register
  // ----------------------------------------------------------------
  wire [3:0] bus_code;
  wire [3:0] seq_code;
  reg [1:0] status;
  reg [15:0] rd16;

  always @* begin
    rd16 = 16'h0000;
    if (grp == G_UPPER) begin
      rd16 = {4'h0, pick12(max_limit_reg, chan)};
    end else if (grp == G_LOWER) begin
      rd16 = {4'h0, pick12(min_limit_reg, chan)};
    end else if (grp == G_HYST) begin
      rd16 = {4'h0, pick12(limit_band_reg, chan)};
    end else if (grp == G_OFFSET) begin
      rd16 = pick16(zero_trim_reg, chan);
    end else if (grp == G_GAIN) begin
      rd16 = pick16(scale_trim_reg, chan);
    end else if (grp == G_SLOT) begin
      rd16 = {12'h000, bus_code};
    end else if (grp == G_STATUS) begin
      rd16 = {14'h0000, status};
    end
  end

  // New value after byte strobes; only lanes 0 and 1 carry bits
  wire [15:0] wr_word;
  assign wr_word = merge16(rd16, pwdata[15:0], pstrb[1:0]);

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------

  // One wait state: pready rises on the second access cycle, so prdata
  // can be registered from the decode instead of driven combinationally
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : {16'h0000, rd16};
      pslverr <= (grp == G_NONE);
    end else begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel banks
  // ----------------------------------------------------------------

  channel_word_bank #(
    .W(`LT_LIMIT_W),
    .RST(`LT_UPPER_RST)
  ) u_upper (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_commit && grp == G_UPPER),
    .wr_chan(chan),
    .wr_data(wr_word[11:0]),
    .words(max_limit_reg)
  );

  channel_word_bank #(
    .W(`LT_LIMIT_W),
    .RST(`LT_LOWER_RST)
  ) u_lower (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_commit && grp == G_LOWER),
    .wr_chan(chan),
    .wr_data(wr_word[11:0]),
    .words(min_limit_reg)
  );

  channel_word_bank #(
    .W(`LT_LIMIT_W),
    .RST(`LT_HYST_RST)
  ) u_hyst (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_commit && grp == G_HYST),
    .wr_chan(chan),
    .wr_data(wr_word[11:0]),
    .words(limit_band_reg)
  );

  channel_word_bank #(
    .W(`LT_TRIM_W),
    .RST(`LT_OFFSET_RST)
  ) u_offset (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_commit && grp == G_OFFSET),
    .wr_chan(chan),
    .wr_data(wr_word),
    .words(zero_trim_reg)
  );

  channel_word_bank #(
    .W(`LT_TRIM_W),
    .RST(`LT_GAIN_RST)
  ) u_gain (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_commit && grp == G_GAIN),
    .wr_chan(chan),
    .wr_data(wr_word),
    .words(scale_trim_reg)
  );

  // ----------------------------------------------------------------
  // Sequencer slot table
  // ----------------------------------------------------------------
  wire slot_wr;
  assign slot_wr = wr_commit && grp == G_SLOT && pstrb[0];

  slot_table u_slots (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(slot_wr),
    .wr_slot(bus_slot),
    .wr_code(pwdata[3:0]),
    .bus_slot(bus_slot),
    .bus_code(bus_code),
    .seq_slot(slot_index),
    .seq_code(seq_code)
  );

  // Registered lookup for the sequencer: answer one cycle after slot_index
  // flag codes above seven
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_input_select <= `LT_SLOT_RST;
      slot_select_valid <= 1'b1;
    end else begin
      slot_input_select <= seq_code;
      slot_select_valid <= (seq_code <= `LT_INPUT_LAST);
    end
  end

  // ----------------------------------------------------------------
  // Sticky status of invalid slot codes
  // ----------------------------------------------------------------
  wire bad_write;
  wire bad_pick;
  wire status_clr;
  assign bad_write = slot_wr && (pwdata[3:0] > `LT_INPUT_LAST);
  // Invalid code seen by the sequencer port, checked on the registered copy
  assign bad_pick = !slot_select_valid;
  assign status_clr = wr_commit && grp == G_STATUS && pstrb[0];

  // Write one to clear; a new event in the same cycle wins over the clear
  // invalid codes recorded
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 2'b00;
    end else begin
      status[`LT_ST_BAD_WRITE] <= bad_write |
        (status[`LT_ST_BAD_WRITE] & ~(status_clr & pwdata[`LT_ST_BAD_WRITE]));
      status[`LT_ST_BAD_PICK] <= bad_pick |
        (status[`LT_ST_BAD_PICK] & ~(status_clr & pwdata[`LT_ST_BAD_PICK]));
    end
  end

endmodule // per_channel_limit_trim_slot_regs

`default_nettype wire

// *** inc/limit_trim_regs.vh ***
// Constants for the per-channel limit, trim and sequencer slot register bank
//
// How it works
// - Eight lower limits from index 0x060, every second index, reset zero.
// - Lower limit field bits 11..0 matches the twelve result MSBs.
// - Eight hysteresis registers from index 0x080, every second index, reset 0x10.
// - Hysteresis uses the same twelve-MSB scale as the limits.
// - Sixteen-bit offset trim per input from index 0x0a0, reset zero, always applied.
// - Sixteen-bit gain trim per input from index 0x0c0, reset 0x8000, always applied.
// - 128 slot entries at 0x100..0x17f; bits 3..0 pick the input, reset zero.
// - Upper limits from index 0x040, twelve-bit field, reset 0x7ff.
`ifndef LIMIT_TRIM_REGS_VH
`define LIMIT_TRIM_REGS_VH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define LT_UPPER_IDX 9'h040
`define LT_LOWER_IDX 9'h060
`define LT_HYST_IDX 9'h080
`define LT_OFFSET_IDX 9'h0a0
`define LT_GAIN_IDX 9'h0c0
`define LT_SLOT_IDX 9'h100
`define LT_STATUS_IDX 9'h1f0
`define LT_CHAN_MASK 9'h1f1
`define LT_SLOT_MASK 9'h180

// ----------------------------------------------------------------
// Address layout of the APB byte address
// ----------------------------------------------------------------
`define LT_ADDR_W 12
`define LT_IDX_MSB 10
`define LT_IDX_LSB 2
`define LT_ADDR_TOP 11

// ----------------------------------------------------------------
// Field widths and reset values
// ----------------------------------------------------------------
`define LT_LIMIT_W 12
`define LT_TRIM_W 16
`define LT_CODE_W 4
`define LT_UPPER_RST 16'h07ff
`define LT_LOWER_RST 16'h0000
`define LT_HYST_RST 16'h0010
`define LT_OFFSET_RST 16'h0000
`define LT_GAIN_RST 16'h8000
`define LT_SLOT_RST 4'h0
`define LT_INPUT_LAST 4'h7

// ----------------------------------------------------------------
// Status register bits
// ----------------------------------------------------------------
`define LT_ST_BAD_WRITE 0
`define LT_ST_BAD_PICK 1

`endif

// *** src/channel_word_bank.v ***
// Eight per-channel words of one register kind, held in flip-flops
`timescale 1ns/1ps
`default_nettype none

module channel_word_bank #(
  parameter W = 16,
  parameter [15:0] RST = 16'h0000
) (
  input wire pclk,
  input wire presetn,
  input wire wr_en,
  input wire [2:0] wr_chan,
  input wire [W-1:0] wr_data,
  output reg [8*W-1:0] words
);

  // One word per channel; the reset value is the same for all eight
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      words <= {8{RST[W-1:0]}};
    end else if (wr_en) begin
      words[wr_chan*W +: W] <= wr_data;
    end
  end

endmodule // channel_word_bank

`default_nettype wire

// *** src/slot_table.v ***
// Sequencer slot table: 128 input-select codes with a bus port and a sequencer port
`timescale 1ns/1ps
`default_nettype none
`include "limit_trim_regs.vh"

module slot_table (
  input wire pclk,
  input wire presetn,
  input wire wr_en,
  input wire [6:0] wr_slot,
  input wire [3:0] wr_code,
  input wire [6:0] bus_slot,
  output wire [3:0] bus_code,
  input wire [6:0] seq_slot,
  output wire [3:0] seq_code
);

  reg [3:0] tbl [0:127];
  integer i;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 128; i = i + 1) begin
        tbl[i] <= `LT_SLOT_RST;
      end
    end else if (wr_en) begin
      tbl[wr_slot] <= wr_code;
    end
  end

  // Two independent read ports so the sequencer never waits on software
  assign bus_code = tbl[bus_slot];
  assign seq_code = tbl[seq_slot];

endmodule // slot_table

`default_nettype wire

// *** tb/per_channel_limit_trim_slot_regs_props.sv ***
// Checker for the limit, trim and slot register bank
`timescale 1ns/1ps
`default_nettype none
module per_channel_limit_trim_slot_regs_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [95:0] min_limit_reg,
  input wire logic [127:0] zero_trim_reg,
  input wire logic [127:0] scale_trim_reg,
  input wire logic [3:0] slot_input_select,
  input wire logic slot_select_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Bus cycle steps
  // ----------------------------------------
  sequence acc_wait;
    psel && penable && !pready;
  endsequence
  sequence wr_done(a);
    psel && penable && pready && pwrite && paddr == a && pstrb[1:0] == 2'b11;
  endsequence
  // Exactly one wait state, answer stands one cycle
  a_one_wait: assert property (acc_wait |=> pready ##1 !pready)
    else $error("ready not one cycle after access");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  a_read_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_limit_resv: assert property (pready && !pwrite && paddr >= 12'h100 && paddr < 12'h280 |-> prdata[31:12] == 20'h0)
    else $error("limit reserved bits set");
  a_slot_resv: assert property (pready && !pwrite && paddr[11:9] == 3'b010 |-> prdata[31:4] == 28'h0)
    else $error("slot reserved bits set");
  a_bad_addr: assert property (pready && (paddr[11] || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("no error on unmapped address");
  a_lower_write: assert property (wr_done(12'h180) |=> min_limit_reg[11:0] == $past(pwdata[11:0]))
    else $error("lower limit write lost");
  a_gain_write: assert property (wr_done(12'h338) |=> scale_trim_reg[127:112] == $past(pwdata[15:0]))
    else $error("gain trim write lost");
  // Offset trims only move through a bus write
  a_trim_hold: assert property (!(psel && penable && pwrite) |=> $stable(zero_trim_reg))
    else $error("offset trim changed without write");
  a_reset_vals: assert property ($rose(presetn) |-> scale_trim_reg == {8{16'h8000}} && zero_trim_reg == 128'h0)
    else $error("trim reset values wrong");
  a_valid_code: assert property (slot_select_valid == (slot_input_select <= 4'h7))
    else $error("slot valid flag wrong");
endmodule // per_channel_limit_trim_slot_regs_props
bind per_channel_limit_trim_slot_regs per_channel_limit_trim_slot_regs_props i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .min_limit_reg(min_limit_reg), .zero_trim_reg(zero_trim_reg),
  .scale_trim_reg(scale_trim_reg), .slot_input_select(slot_input_select),
  .slot_select_valid(slot_select_valid)
);
`default_nettype wire

// *** tb/per_channel_limit_trim_slot_regs_tb.sv ***
// Self-checking bench for the limit, trim and slot register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module per_channel_limit_trim_slot_regs_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slot_select_valid, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [3:0] pstrb, slot_input_select, s;
  logic [6:0] slot_index;
  logic [95:0] max_limit_reg, min_limit_reg, limit_band_reg;
  logic [127:0] zero_trim_reg, scale_trim_reg;
  logic [15:0] exp_reg [5][8];
  logic [3:0] exp_slot [128];
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int k, c;
  per_channel_limit_trim_slot_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .max_limit_reg(max_limit_reg), .min_limit_reg(min_limit_reg),
    .limit_band_reg(limit_band_reg), .zero_trim_reg(zero_trim_reg), .scale_trim_reg(scale_trim_reg),
    .slot_index(slot_index), .slot_input_select(slot_input_select), .slot_select_valid(slot_select_valid));
  // ----------------------------------------
  // Expectation helpers
  // ----------------------------------------
  function automatic logic [15:0] rst_val(int kind);
    return kind == 0 ? 16'h07ff : kind == 2 ? 16'h0010 : kind == 4 ? 16'h8000 : 16'h0000;
  endfunction
  // Strobe-off bytes keep the old value; limits drop the reserved nibble
  function automatic logic [15:0] merge(logic [15:0] o, logic [31:0] v, logic [3:0] st, int kind);
    return {st[1] ? v[15:8] : o[15:8], st[0] ? v[7:0] : o[7:0]} & (kind < 3 ? 16'h0fff : 16'hffff);
  endfunction
  function automatic logic [11:0] radr(int kind, int ch);
    return 12'h100 + 12'(kind * 128 + ch * 8);
  endfunction
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v, input logic [3:0] st);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // No assumed wait count: only the cycle guard ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic reset_expect();
    for (int i = 0; i < 40; i++) exp_reg[i / 8][i % 8] = rst_val(i / 8);
    for (int i = 0; i < 128; i++) exp_slot[i] = 4'h0;
  endtask
  // Reads every channel register and compares the bank outputs too
  task automatic read_all();
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, radr(i / 8, i % 8), 32'h0, 4'h0);
      `CHK(rd, {16'h0, exp_reg[i / 8][i % 8]})
      `CHK(err, 1'b0)
    end
    for (int i = 0; i < 8; i++) begin
      `CHK(max_limit_reg[12*i+:12], exp_reg[0][i][11:0])
      `CHK(min_limit_reg[12*i+:12], exp_reg[1][i][11:0])
      `CHK(limit_band_reg[12*i+:12], exp_reg[2][i][11:0])
      `CHK(zero_trim_reg[16*i+:16], exp_reg[3][i])
      `CHK(scale_trim_reg[16*i+:16], exp_reg[4][i])
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, slot_index} = '0;
    rd = $urandom(32'hdccc6662);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    reset_expect();
    read_all();
    $display("test reset values done");
    // Full-strobe pass over every register, then random strobes
    for (int i = 0; i < 100; i++) begin
      k = i < 40 ? i / 8 : $urandom % 5;
      c = i < 40 ? i % 8 : $urandom % 8;
      s = i < 40 ? 4'hf : 4'($urandom);
      d = $urandom;
      apb(1'b1, radr(k, c), d, s);
      exp_reg[k][c] = merge(exp_reg[k][c], d, s, k);
    end
    read_all();
    $display("test channel writes done");
    // Slot codes stay in 0..7 except one deliberate bad code at the end
    for (int i = 0; i < 128; i++) begin
      d = $urandom;
      d[3:0] = i == 127 ? 4'hf : 4'($urandom % 8);
      exp_slot[i] = d[3:0];
      apb(1'b1, 12'h400 + 12'(i * 4), d, 4'hf);
    end
    for (int i = 0; i < 128; i++) begin
      apb(1'b0, 12'h400 + 12'(i * 4), 32'h0, 4'h0);
      `CHK(rd, {28'h0, exp_slot[i]})
      slot_index <= 7'(i);
      @(posedge pclk);
      #1;
      `CHK(slot_input_select, exp_slot[i])
      `CHK(slot_select_valid, exp_slot[i] <= 4'h7)
    end
    $display("test slot table done");
    // Sticky flags: bad code written and delivered; a live bad pick beats its clear
    apb(1'b0, 12'h7c0, 32'h0, 4'h0);
    `CHK(rd, 32'h0000_0003)
    apb(1'b1, 12'h7c0, 32'h0000_0003, 4'h1);
    apb(1'b0, 12'h7c0, 32'h0, 4'h0);
    `CHK(rd, 32'h0000_0002)
    slot_index <= 7'h00;
    apb(1'b1, 12'h7c0, 32'h0000_0003, 4'h1);
    apb(1'b0, 12'h7c0, 32'h0, 4'h0);
    `CHK(rd, 32'h0000_0000)
    $display("test status flags done");
    // Unmapped places answer with an error and change nothing
    for (int i = 0; i < 4; i++) begin
      d = i == 0 ? 12'h104 : i == 1 ? 12'h802 : i == 2 ? 12'h101 : 12'h3fc;
      apb(1'b1, d[11:0], $urandom, 4'hf);
      `CHK(err, 1'b1)
      apb(1'b0, d[11:0], 32'h0, 4'h0);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h0)
    end
    read_all();
    $display("test unmapped done");
    // Reset in mid-run restores every value
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reset_expect();
    read_all();
    apb(1'b0, 12'h5fc, 32'h0, 4'h0);
    `CHK(rd, 32'h0)
    $display("test second reset done");
    report_and_stop();
  end
endmodule // per_channel_limit_trim_slot_regs_tb
`default_nettype wire
